// file: src/cie_core.sv
`timescale 1ns/1ps
`include "cie_cfg.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module cie_core
  import cie_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // instruction from program memory, one per instruction cycle
  input wire logic [15:0] instr,
  // data register file
  output logic [7:0] file_addr,
  output logic file_rd,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  // core state
  output logic [7:0] working_register,
  output logic [7:0] alu_flags_register,
  output logic [7:0] pc_low_byte,
  output logic [7:0] pc_high_byte,
  output logic [7:0] pc_high_latch,
  output logic [7:0] bank_select_register,
  // instruction cycle phase and divided clock
  output logic instr_strobe,
  output logic divided_clock_output
);
  cie_alu_if alu_b ();
  cie_alu u_alu (.a(alu_b));

  //------------------------------------------------------------
  // phase counter
  //------------------------------------------------------------
  cie_phase_type ph_r, ph_nxt;
  logic clko_r, clko_nxt;
  always_comb
  begin
    ph_nxt = (ph_r == cie_q4) ? cie_q1 : cie_phase_type'(ph_r + 2'd1);
    // high during q1-q2, low q3-q4: period of four oscillator cycles
    clko_nxt = (ph_nxt == cie_q1) || (ph_nxt == cie_q2);
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ph_r <= cie_q1;
      clko_r <= 1'b1;
    end
    else
    begin
      ph_r <= ph_nxt;
      clko_r <= clko_nxt;
    end
  end
  assign divided_clock_output = clko_r;
  assign instr_strobe = (ph_r == cie_q1);

  //------------------------------------------------------------
  // decode
  //------------------------------------------------------------
  function automatic cie_op_type decode(input logic [15:0] i);
    if (i == 16'h0000)
      decode = cie_op_nop_type_e;
    else if (i[15:13] == 3'b011)
      decode = cie_op_to_periph;
    else if (i[15:8] == 8'hb8 && i[7:4] == 4'h0)
      decode = cie_op_bank_lo;
    else if (i[15:9] == 7'b0010110)
      decode = cie_op_negate;
    else if (i[15:9] == 7'b0010100)
      decode = cie_op_clear;
    // bank load with a nonzero unused field must not fall into the bit ops
    else if (i[15:14] == 2'b10 && i[11] && i[15:8] != 8'hb8)
      decode = cie_op_bitop;
    else if (i[15:8] == 8'h01)
      decode = cie_op_store_w;
    else
      decode = cie_op_nop_type_e;
  endfunction : decode

  // operand byte is captured in q2: in q4 the file address shows the destination
  logic [15:0] ir_r, ir_nxt;
  logic [7:0] rd_r, rd_nxt;
  cie_op_type op;
  always_comb
  begin
    ir_nxt = (ph_r == cie_q1) ? instr : ir_r;
    rd_nxt = file_rd ? file_rdata : rd_r;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ir_r <= 16'h0000;
      rd_r <= `CIE_RST_BYTE;
    end
    else
    begin
      ir_r <= ir_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign op = decode(ir_r);

  //------------------------------------------------------------
  // operand read and execute
  //------------------------------------------------------------
  logic [7:0] faddr, daddr, src;
  logic [7:0] wr_val;
  logic to_file, to_w, rd_src, set_fl, clear_file_register_any, bitop_v;
  logic [7:0] w_r, w_nxt, fl_r, fl_nxt, pclo_r, pclo_nxt;
  logic [7:0] pchi_r, pchi_nxt, lat_r, lat_nxt, bank_r, bank_nxt;
  always_comb
  begin
    faddr = ir_r[7:0];
    daddr = faddr;
    to_file = 1'b0;
    to_w = 1'b0;
    rd_src = 1'b0;
    set_fl = 1'b0;
    alu_b.fn = 2'd0;
    alu_b.opa = 8'h00;
    alu_b.opb = 8'h00;
    bitop_v = 1'b0;
    clear_file_register_any = 1'b0;
    case (op)
      cie_op_to_periph:
      begin
        rd_src = 1'b1;
        daddr = {3'b000, ir_r[12:8]};
        to_file = 1'b1;
      end
      cie_op_negate:
      begin
        alu_b.fn = 2'd1;
        alu_b.opb = w_r;
        set_fl = 1'b1;
        to_file = 1'b1;
        to_w = ~ir_r[8];
      end
      cie_op_clear:
      begin
        alu_b.opb = 8'h00;
        set_fl = 1'b1;
        clear_file_register_any = 1'b1;
        to_file = 1'b1;
        to_w = ~ir_r[8];
      end
      cie_op_bitop:
      begin
        rd_src = 1'b1;
        bitop_v = 1'b1;
        to_file = 1'b1;
      end
      cie_op_store_w:
      begin
        alu_b.opb = w_r;
        to_file = 1'b1;
      end
      default:
        to_file = 1'b0;
    endcase
  end

  // source value, special registers answered inside the core
  function automatic logic [7:0] rd_sel(input logic [7:0] ad, input logic [7:0] ext,
    input logic [7:0] w, input logic [7:0] fl, input logic [7:0] pl,
    input logic [7:0] lat, input logic [7:0] bs);
    if (ad == `CIE_ADDR_WORK)
      rd_sel = w;
    else if (ad == `CIE_ADDR_ALU)
      rd_sel = fl;
    else if (ad == `CIE_ADDR_PC_LO)
      rd_sel = pl;
    else if (ad == `CIE_ADDR_PC_LATCH)
      rd_sel = lat;
    else if (ad == `CIE_ADDR_BANK)
      rd_sel = bs;
    else
      rd_sel = ext;
  endfunction : rd_sel

  logic [7:0] bit_mask, bit_res;
  logic exec;
  assign exec = (ph_r == cie_q4);
  assign src = rd_sel(faddr, rd_r, w_r, fl_r, pclo_r, lat_r, bank_r);
  always_comb
  begin
    bit_mask = 8'h01 << ir_r[10:8];
    // op 00 set, 01 clear, 10 and 11 toggle the selected bit only
    case (ir_r[13:12])
      2'b00: bit_res = src | bit_mask;
      2'b01: bit_res = src & ~bit_mask;
      default: bit_res = src ^ bit_mask;
    endcase
    if (bitop_v)
      wr_val = bit_res;
    else if (op == cie_op_to_periph)
      wr_val = src;
    else
      wr_val = alu_b.res;
  end

  always_comb
  begin
    w_nxt = w_r;
    fl_nxt = fl_r;
    pclo_nxt = pclo_r;
    pchi_nxt = pchi_r;
    lat_nxt = lat_r;
    bank_nxt = bank_r;
    if (exec)
    begin
      if (rd_src && faddr == `CIE_ADDR_PC_LO)
        lat_nxt = pchi_r;
      if (op == cie_op_bank_lo)
        bank_nxt = {bank_r[7:4], ir_r[3:0]};
      if (to_w || daddr == `CIE_ADDR_WORK && to_file)
        w_nxt = wr_val;
      if (to_file)
      begin
        if (daddr == `CIE_ADDR_ALU)
          fl_nxt = wr_val;
        else if (daddr == `CIE_ADDR_PC_LO)
        begin
          pclo_nxt = wr_val;
          pchi_nxt = lat_r;
        end
        else if (daddr == `CIE_ADDR_PC_LATCH)
          lat_nxt = wr_val;
        else if (daddr == `CIE_ADDR_BANK)
          bank_nxt = wr_val;
      end
      if (set_fl)
      begin
        // flags from the instruction win over the stored byte
        fl_nxt[`CIE_FLAG_Z] = alu_b.flags[`CIE_FLAG_Z];
        if (!clear_file_register_any)
          fl_nxt[`CIE_FLAG_OVF:`CIE_FLAG_C] = alu_b.flags;
        else if (daddr == `CIE_ADDR_ALU)
          fl_nxt[`CIE_FLAG_OVF:`CIE_FLAG_C] = 4'b0100;
      end
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      w_r <= `CIE_RST_BYTE;
      fl_r <= `CIE_RST_BYTE;
      pclo_r <= `CIE_RST_BYTE;
      pchi_r <= `CIE_RST_BYTE;
      lat_r <= `CIE_RST_BYTE;
      bank_r <= `CIE_RST_BYTE;
    end
    else
    begin
      w_r <= w_nxt;
      fl_r <= fl_nxt;
      pclo_r <= pclo_nxt;
      pchi_r <= pchi_nxt;
      lat_r <= lat_nxt;
      bank_r <= bank_nxt;
    end
  end

  // file bus: read in q2, write in q4; nop touches neither
  always_comb
  begin
    file_rd = (ph_r == cie_q2) && rd_src;
    file_addr = exec ? daddr : faddr;
    file_we = exec && to_file && daddr > `CIE_ADDR_BANK;
    file_wdata = wr_val;
  end
  assign working_register = w_r;
  assign alu_flags_register = fl_r;
  assign pc_low_byte = pclo_r;
  assign pc_high_byte = pchi_r;
  assign pc_high_latch = lat_r;
  assign bank_select_register = bank_r;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  sequence s_quarter;
    divided_clock_output ##1 divided_clock_output ##1 !divided_clock_output
      ##1 !divided_clock_output;
  endsequence
  a_clk_quarter: assert property (@(posedge clk_sys) disable iff (srst)
    (ph_r == cie_q1) |-> s_quarter)
    else $error("divided clock not a quarter rate");
  a_nop_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    (op == cie_op_nop_type_e) |-> !file_we && !file_rd)
    else $error("nop touched the file bus");
  a_load_bank_low_nibble_upper: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == cie_op_bank_lo) |=> bank_r == {$past(bank_r[7:4]), $past(ir_r[3:0])})
    else $error("bank load wrong");
  a_move_flags: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == cie_op_to_periph && daddr != `CIE_ADDR_ALU) |=> $stable(fl_r))
    else $error("peripheral move changed flags");
  a_pclo_read: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && rd_src && faddr == `CIE_ADDR_PC_LO && daddr != `CIE_ADDR_PC_LATCH)
      |=> lat_r == $past(pchi_r))
    else $error("pc high not latched");
  a_pclo_write: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && to_file && daddr == `CIE_ADDR_PC_LO) |=> pchi_r == $past(lat_r))
    else $error("pc high not loaded");
  a_clear_alu: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == cie_op_clear && daddr == `CIE_ADDR_ALU) |=> fl_r == 8'h04)
    else $error("cleared flags not 04");
  a_negate_dest: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && op == cie_op_negate && !ir_r[8]) |=> w_r == 8'h00 - $past(w_r))
    else $error("negate result missing in working register");
  // setting a bit that is already set changes nothing, so only the other bits are held
  a_bit_whole: assert property (@(posedge clk_sys) disable iff (srst)
    (exec && bitop_v) |-> ((wr_val ^ src) & ~bit_mask) == 8'h00)
    else $error("bit op changed an unselected bit");
endmodule : cie_core

// file: src/cie_cfg.svh
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH
// alu flag bit positions
`define CIE_FLAG_C 0
`define CIE_FLAG_DIG 1
`define CIE_FLAG_Z 2
`define CIE_FLAG_OVF 3
// reserved file addresses inside the core
`define CIE_ADDR_WORK 8'h0a
`define CIE_ADDR_ALU 8'h04
`define CIE_ADDR_PC_LO 8'h02
`define CIE_ADDR_PC_LATCH 8'h03
`define CIE_ADDR_BANK 8'h0f
// reset values
`define CIE_RST_BYTE 8'h00
`define CIE_RST_FLAGS 4'h0
// oscillator periods per instruction cycle
`define CIE_Q_PER_CYCLE 4
`endif

// file: src/cie_pkg.sv
package cie_pkg;
  typedef enum logic [2:0] {
    cie_op_nop_type_e,
    cie_op_to_periph,
    cie_op_bank_lo,
    cie_op_negate,
    cie_op_clear,
    cie_op_bitop,
    cie_op_store_w
  } cie_op_type;
  typedef enum logic [1:0] {
    cie_q1,
    cie_q2,
    cie_q3,
    cie_q4
  } cie_phase_type;
endpackage : cie_pkg

// file: src/cie_alu_if.sv
`timescale 1ns/1ps
interface cie_alu_if;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [1:0] fn;
  logic [7:0] res;
  logic [3:0] flags;
  modport core (output opa, output opb, output fn, input res, input flags);
  modport alu (input opa, input opb, input fn, output res, output flags);
endinterface : cie_alu_if

// file: src/cie_alu.sv
`timescale 1ns/1ps
`include "cie_cfg.svh"
module cie_alu
  import cie_pkg::*;
(
  cie_alu_if.alu a
);
  logic [8:0] sum;
  logic [4:0] lo;
  always_comb
  begin
    sum = {1'b0, a.opa} + {1'b0, a.opb};
    lo = {1'b0, a.opa[3:0]} + {1'b0, a.opb[3:0]};
    a.res = sum[7:0];
    a.flags = `CIE_RST_FLAGS;
    // fn 0: pass opb, fn 1: negate opb, fn 2: add
    case (a.fn)
      2'd1:
      begin
        sum = {1'b0, ~a.opb} + 9'h001;
        lo = {1'b0, ~a.opb[3:0]} + 5'h01;
        a.res = sum[7:0];
        a.flags[`CIE_FLAG_C] = sum[8];
        a.flags[`CIE_FLAG_DIG] = lo[4];
        a.flags[`CIE_FLAG_OVF] = a.opb[7] & sum[7];
      end
      2'd2:
      begin
        a.flags[`CIE_FLAG_C] = sum[8];
        a.flags[`CIE_FLAG_DIG] = lo[4];
        a.flags[`CIE_FLAG_OVF] = (a.opa[7] == a.opb[7]) & (sum[7] != a.opa[7]);
      end
      default:
        a.res = a.opb;
    endcase
    a.flags[`CIE_FLAG_Z] = (a.res == 8'h00);
  end
endmodule : cie_alu

// file: dv/cie_file_model.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// data register file model
//------------------------------------------------------------
module cie_file_model
(
  // clock
  input wire logic clk_sys,
  // file access
  input wire logic [7:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:255];
  // read is combinational: the core samples it in q2 of the instruction cycle
  assign file_rdata = mem[file_addr];
  always @(posedge clk_sys)
  begin
    if (file_we === 1'b1)
    begin
      mem[file_addr] <= file_wdata;
    end
  end
endmodule : cie_file_model

// file: dv/test_cie_core.sv
`timescale 1ns/1ps
module test_cie_core;
  import cie_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic [7:0] file_addr, file_rdata, file_wdata, w_reg, flags, pc_lo, pc_hi, pclat, bank;
  logic file_rd, file_we, instr_strobe, divided_clock_output;
  int err_count = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (file_we === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
    end
    if (file_rd === 1'b1)
    begin
      rd_cnt <= rd_cnt + 1;
    end
  end
  cie_core u_cie_core (.clk_sys(clk_sys), .srst(srst), .instr(instr), .file_addr(file_addr),
    .file_rd(file_rd), .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata),
    .working_register(w_reg), .alu_flags_register(flags), .pc_low_byte(pc_lo),
    .pc_high_byte(pc_hi),
    .pc_high_latch(pclat), .bank_select_register(bank), .instr_strobe(instr_strobe),
    .divided_clock_output(divided_clock_output));
  cie_file_model u_cie_file_model (.clk_sys(clk_sys), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata));
  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one instruction per four cycles; nop is put back so it is not repeated
  task exec(input logic [15:0] op);
    int n;
    n = 0;
    while (instr_strobe !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    instr = op;
    @(negedge clk_sys);
    instr = 16'h0000;
    repeat (3) @(negedge clk_sys);
  endtask : exec
  function automatic logic [15:0] mfp(input logic [4:0] p, input logic [7:0] f);
    return {3'h3, p, f};
  endfunction : mfp
  task conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task t_nop();
    exec(16'h0000);
    exec(16'hffff);
    exec(16'hb835);
    chk(w_reg, 8'h00);
    chk(flags | bank | pc_lo | pc_hi, 8'h00);
    chk(wr_cnt[7:0], 8'h00);
    chk(rd_cnt[7:0], 8'h00);
    $display("test nop done");
  endtask : t_nop
  task t_to_periph();
    u_cie_file_model.mem[8'h40] = 8'h33;
    exec(16'h2904);
    chk(flags, 8'h04);
    exec(mfp(5'h11, 8'h40));
    chk(u_cie_file_model.mem[8'h11], 8'h33);
    chk(flags, 8'h04);
    chk(wr_cnt[7:0], 8'h01);
    chk(rd_cnt[7:0], 8'h01);
    $display("test peripheral move done");
  endtask : t_to_periph
  task t_bank_lo();
    u_cie_file_model.mem[8'h41] = 8'ha3;
    exec(mfp(5'h0f, 8'h41));
    exec(16'hb805);
    chk(bank, 8'ha5);
    exec(16'hb80c);
    chk(bank, 8'hac);
    $display("test bank load done");
  endtask : t_bank_lo
  task t_negate();
    u_cie_file_model.mem[8'h42] = 8'h3a;
    u_cie_file_model.mem[8'h43] = 8'h80;
    u_cie_file_model.mem[8'h44] = 8'h00;
    exec(mfp(5'h0a, 8'h44));
    exec(16'h2d52);
    chk(flags, 8'h07);
    exec(mfp(5'h0a, 8'h42));
    exec(16'h2c50);
    chk(u_cie_file_model.mem[8'h50], 8'hc6);
    chk(w_reg, 8'hc6);
    chk(flags, 8'h00);
    exec(16'h2d51);
    chk(u_cie_file_model.mem[8'h51], 8'h3a);
    chk(w_reg, 8'hc6);
    exec(mfp(5'h0a, 8'h43));
    exec(16'h2d53);
    chk(flags, 8'h0a);
    $display("test negate done");
  endtask : t_negate
  task t_pc_lo();
    u_cie_file_model.mem[8'h60] = 8'h80;
    u_cie_file_model.mem[8'h61] = 8'h12;
    u_cie_file_model.mem[8'h62] = 8'h00;
    exec(mfp(5'h03, 8'h61));
    exec(mfp(5'h02, 8'h60));
    chk(pc_lo, 8'h80);
    chk(pc_hi, 8'h12);
    exec(mfp(5'h03, 8'h62));
    chk(pclat, 8'h00);
    exec(mfp(5'h0a, 8'h02));
    chk(w_reg, 8'h80);
    chk(pclat, 8'h12);
    $display("test pc low done");
  endtask : t_pc_lo
  // set bit 7, clear bit 0, toggle bit 4, set bit 7 again, then toggle pc low bit 0
  task t_bit_ops();
    u_cie_file_model.mem[8'h70] = 8'h0f;
    exec(16'h8f70);
    chk(u_cie_file_model.mem[8'h70], 8'h8f);
    exec(16'h9870);
    chk(u_cie_file_model.mem[8'h70], 8'h8e);
    exec(16'hac70);
    chk(u_cie_file_model.mem[8'h70], 8'h9e);
    exec(16'h8f70);
    chk(u_cie_file_model.mem[8'h70], 8'h9e);
    exec(mfp(5'h03, 8'h62));
    exec(16'ha802);
    chk(pc_lo, 8'h81);
    chk(pc_hi, 8'h00);
    $display("test bit ops done");
  endtask : t_bit_ops
  task t_clk();
    int i;
    exec(16'h0000);
    for (i = 0; i < 8; i++)
    begin
      chk({7'h00, divided_clock_output}, {7'h00, (i % 4) < 2});
      chk({7'h00, instr_strobe}, {7'h00, (i % 4) == 0});
      @(negedge clk_sys);
    end
    $display("test clock done");
  endtask : t_clk
  //------------------------------------------------------------
  // main sequence and watchdog
  //------------------------------------------------------------
  initial
  begin
    repeat (8) @(negedge clk_sys);
    srst = 1'b0;
    t_nop();
    t_to_periph();
    t_bank_lo();
    t_negate();
    t_pc_lo();
    t_bit_ops();
    t_clk();
    conclude();
  end
  // about 30 instructions of 20 ns each are expected; allow a wide margin
  initial
  begin
    #20000;
    err_count++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end
endmodule : test_cie_core
